// file: inc/port_pkg.sv
// Constants for the pin mode, port latch and power control block
package port_pkg;
    // Special function register addresses
    localparam logic [7:0] ADDR_PORT0 = 8'h80;
    localparam logic [7:0] ADDR_POWER = 8'h87;
    localparam logic [7:0] ADDR_PORT1 = 8'h90;
    localparam logic [7:0] ADDR_INDEX = 8'h91;
    localparam logic [7:0] ADDR_PORT3 = 8'hB0;
    localparam logic [7:0] ADDR_MODE10 = 8'hA2;
    localparam logic [7:0] ADDR_MODE32 = 8'hA3;
    localparam logic [7:0] ADDR_MODE54 = 8'hA4;
    localparam logic [7:0] ADDR_MODE76 = 8'hA5;
    localparam logic [7:0] ADDR_PINCFG = 8'hA6;
    localparam logic [7:0] ADDR_IRQEN = 8'hA8;
    // Reset values
    localparam logic [7:0] RST_PORT0 = 8'h3F;
    localparam logic [7:0] RST_PORT13 = 8'hFF;
    localparam logic [7:0] RST_MODE = 8'h11;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Valid bits of port 0 latch
    localparam logic [7:0] MASK_PORT0 = 8'h3F;
    // Field positions
    localparam int BIT_HALT = 1;
    localparam int BIT_IDLE = 0;
    localparam int BIT_GIE = 7;
    localparam int BIT_EX1 = 2;
    localparam int BIT_EX0 = 0;
    localparam int BIT_HS2 = 7;
    localparam int BIT_HS1 = 6;
    localparam int BIT_HS0 = 5;
    // Writable bit masks
    localparam logic [7:0] MASK_POWER = 8'h8F;
    localparam logic [7:0] MASK_PINCFG = 8'hF7;
    localparam logic [7:0] MASK_IRQEN = 8'hBF;
    // Index of the missing port
    localparam logic [1:0] IDX_NONE = 2'h2;
    // Pin mode codes
    localparam logic [3:0] MODE_ANALOG = 4'h3;
    localparam logic [3:0] MODE_PWM = 4'hB;
    localparam logic [3:0] MODE_LCD = 4'hF;
    localparam logic [3:0] MODE_NONE = 4'h7;
    // Number of pins in one port
    localparam int PORT_PINS = 8;
endpackage : port_pkg

// file: logic/pin_cell.sv
// One pin: mode decode into pad controls and wake qualification
`timescale 1ns/10ps
module pin_cell (
    input wire logic [3:0] i_mode,  // Pin mode code
    input wire logic i_latch,       // Data latch bit
    output logic o_drv_low,         // Drive pad low
    output logic o_drv_high,        // Drive pad high
    output logic o_pull_up,         // Pull-up on
    output logic o_pull_down,       // Pull-down on
    output logic o_in_en,           // Digital input on
    output logic o_analog,          // Analog channel routing
    output logic o_pwm,             // PWM or clock routing
    output logic o_lcd,             // LCD bias routing
    output logic o_wake_cap         // Pin may wake and raise change
);
    logic open_drain;
    // Decode of mode code into pad controls
    always_comb begin
        open_drain = (i_mode[1] == 1'b0);
        o_drv_low = 1'b0;
        o_drv_high = 1'b0;
        o_pull_up = 1'b0;
        o_pull_down = 1'b0;
        o_in_en = 1'b0;
        o_analog = 1'b0;
        o_pwm = 1'b0;
        o_lcd = 1'b0;
        if (open_drain) begin
            o_drv_low = ~i_latch;
            o_in_en = i_latch;
            if (i_mode[0] == 1'b0) begin
                o_pull_up = i_latch & ~i_mode[2];
                o_pull_down = i_latch & i_mode[2];
            end
            // plain open drain leaves Hi-Z when latch is one
        end else if (i_mode[0] == 1'b0) begin
            o_drv_low = ~i_latch;
            o_drv_high = i_latch;
        end else begin
            o_analog = (i_mode == port_pkg::MODE_ANALOG);
            o_pwm = (i_mode == port_pkg::MODE_PWM);
            o_lcd = (i_mode == port_pkg::MODE_LCD);
            o_pull_up = (i_mode == port_pkg::MODE_LCD);
            o_pull_down = (i_mode == port_pkg::MODE_LCD);
        end
        o_wake_cap = open_drain;
    end
endmodule : pin_cell

// file: logic/port_pin_mode_wakeup.sv
// Ports 0, 1 and 3 with pin modes, high sink and power mode wake control
`timescale 1ns/10ps
// Summary of operation
// - Pull-up open drain: low or pulled up
// - Pull-down open drain: low or pulled down
// - Plain open drain: low or Hi-Z
// - Push-pull drives both levels, no input
// - Codes 3, 11, 15 route alternate functions
// - Read-modify-write reads latch not pin
// - Index picks port; high nibble odd pin
// - Port index never holds value two
// - Only open drain pins wake or interrupt
// - External enable alone arms halt wake
// - After halt wake next instruction first
// - Idle ends only on fully enabled interrupt
// - Power bits enter halt and idle
// - Three enables switch high sink groups
// - Mode registers reset to code one
module port_pin_mode_wakeup (
    input wire logic i_clk,               // System clock
    input wire logic i_rst_b,             // Asynchronous reset, active low
    input wire logic [7:0] i_sfr_addr,    // Register address
    input wire logic i_sfr_wr,            // Write strobe
    input wire logic i_sfr_rd,            // Read strobe
    input wire logic i_sfr_rmw,           // Read is part of read-modify-write
    input wire logic [7:0] i_sfr_wdata,   // Write data
    input wire logic [7:0] i_pin0,        // Port 0 pad levels
    input wire logic [7:0] i_pin1,        // Port 1 pad levels
    input wire logic [7:0] i_pin3,        // Port 3 pad levels
    input wire logic [1:0] i_ext_irq_pin, // External interrupt pin levels
    input wire logic i_irq_pending,       // Any enabled interrupt pending
    input wire logic i_isr_done,          // Service routine returned
    output logic [7:0] o_sfr_rdata,       // Read data
    output logic [23:0] o_drv_low,        // Pad drive low, port 0,1,3
    output logic [23:0] o_drv_high,       // Pad drive high
    output logic [23:0] o_pull_up,        // Pull-up on
    output logic [23:0] o_pull_down,      // Pull-down on
    output logic [23:0] o_in_en,          // Digital input on
    output logic [23:0] o_analog,         // Analog routing
    output logic [23:0] o_pwm,            // PWM or clock routing
    output logic [23:0] o_lcd,            // LCD bias routing
    output logic [23:0] o_wake_cap,       // Pin wake capable
    output logic [23:0] o_high_sink,      // High sink enable per pin
    output logic o_halt,                  // Halt/stop active, clock stop
    output logic o_idle,                  // Idle active, CPU held
    output logic o_wake_req,              // Halt wake request to oscillator
    output logic o_isr_enter,             // Enter service after wake
    output logic o_resume_next            // Pulse: execute post halt instruction
);
    typedef struct packed {
        logic [7:0] port0_data_latch;
        logic [7:0] port1_data_latch;
        logic [7:0] port3_data_latch;
        logic [7:0] power_control;
        logic [1:0] port_select_index;
        logic [7:0] pin_cfg;
        logic [7:0] irq_en;
        logic [0:2][0:3][7:0] mode;
        logic [7:0] rdata;
        logic [23:0] drv_low, drv_high, pull_up, pull_down, in_en;
        logic [23:0] analog, pwm, lcd, wake_cap, high_sink;
        logic wake_req, isr_enter, resume_next;
        logic [1:0] ext_s1, ext_s2;
        logic [23:0] pin_s1, pin_s2;
    } state_t;
    state_t state_reg;
    state_t state_next;
    logic [23:0] latch_all;
    logic [23:0] pin_raw;
    logic [95:0] mode_all;
    logic [23:0] c_low, c_high, c_pu, c_pd, c_in, c_an, c_pw, c_lc, c_wk;
    logic wake_async;
    logic [1:0] pidx;
    logic [1:0] pw;

    assign latch_all = {state_reg.port3_data_latch, state_reg.port1_data_latch,
                        state_reg.port0_data_latch};
    assign pin_raw = {i_pin3, i_pin1, i_pin0};
    // Pin mode fields flattened, pin n uses nibble n of its port
    always_comb begin
        mode_all = '0;
        for (int p = 0; p < 3; p++) begin
            for (int r = 0; r < 4; r++) begin
                mode_all[p*32 + r*8 +: 8] = state_reg.mode[p][r];
            end
        end
    end

    // One decode cell per pin
    for (genvar g = 0; g < 3 * port_pkg::PORT_PINS; g++) begin : g_pin
        pin_cell u_cell (
            .i_mode(mode_all[g*4 +: 4]),
            .i_latch(latch_all[g]),
            .o_drv_low(c_low[g]),
            .o_drv_high(c_high[g]),
            .o_pull_up(c_pu[g]),
            .o_pull_down(c_pd[g]),
            .o_in_en(c_in[g]),
            .o_analog(c_an[g]),
            .o_pwm(c_pw[g]),
            .o_lcd(c_lc[g]),
            .o_wake_cap(c_wk[g])
        );
    end

    // clockless wake term; low level on an open drain input pin or armed low external pin
    always_comb begin
        wake_async = 1'b0;
        for (int i = 0; i < 24; i++) begin
            wake_async = wake_async | (c_wk[i] & c_in[i] & ~pin_raw[i]);
        end
        // individual enable alone arms the pin
        wake_async = wake_async |
            (state_reg.irq_en[port_pkg::BIT_EX0] & ~i_ext_irq_pin[0]) |
            (state_reg.irq_en[port_pkg::BIT_EX1] & ~i_ext_irq_pin[1]);
    end

    // Next state: register writes, reads, power sequencing
    always_comb begin
        state_next = state_reg;
        pidx = state_reg.port_select_index;
        pw = 2'h0;
        state_next.ext_s1 = i_ext_irq_pin;
        state_next.ext_s2 = state_reg.ext_s1;
        state_next.pin_s1 = pin_raw;
        state_next.pin_s2 = state_reg.pin_s1;
        state_next.resume_next = 1'b0;
        // Port slot 0,1,2 for index 0,1,3
        pw = (pidx == 2'h3) ? 2'h2 : pidx;
        if (i_sfr_wr) begin
            unique case (i_sfr_addr)
                port_pkg::ADDR_PORT0:
                    state_next.port0_data_latch = i_sfr_wdata & port_pkg::MASK_PORT0;
                port_pkg::ADDR_PORT1: state_next.port1_data_latch = i_sfr_wdata;
                port_pkg::ADDR_PORT3: state_next.port3_data_latch = i_sfr_wdata;
                // power bits enter halt or idle
                port_pkg::ADDR_POWER:
                    state_next.power_control = i_sfr_wdata & port_pkg::MASK_POWER;
                port_pkg::ADDR_INDEX: begin
                    // value two is refused, index keeps old port
                    if (i_sfr_wdata[1:0] != port_pkg::IDX_NONE) begin
                        state_next.port_select_index = i_sfr_wdata[1:0];
                    end
                end
                // index selects the port of the mode registers
                port_pkg::ADDR_MODE10: state_next.mode[pw][0] = i_sfr_wdata;
                port_pkg::ADDR_MODE32: state_next.mode[pw][1] = i_sfr_wdata;
                port_pkg::ADDR_MODE54: state_next.mode[pw][2] = i_sfr_wdata;
                port_pkg::ADDR_MODE76: state_next.mode[pw][3] = i_sfr_wdata;
                port_pkg::ADDR_PINCFG:
                    state_next.pin_cfg = i_sfr_wdata & port_pkg::MASK_PINCFG;
                port_pkg::ADDR_IRQEN:
                    state_next.irq_en = i_sfr_wdata & port_pkg::MASK_IRQEN;
                default: ;
            endcase
        end
        if (i_sfr_rd) begin
            unique case (i_sfr_addr)
                // read-modify-write sees latch, plain read sees pins
                port_pkg::ADDR_PORT0: state_next.rdata = i_sfr_rmw ?
                    state_reg.port0_data_latch : (state_reg.pin_s2[7:0] & port_pkg::MASK_PORT0);
                port_pkg::ADDR_PORT1: state_next.rdata = i_sfr_rmw ?
                    state_reg.port1_data_latch : state_reg.pin_s2[15:8];
                port_pkg::ADDR_PORT3: state_next.rdata = i_sfr_rmw ?
                    state_reg.port3_data_latch : state_reg.pin_s2[23:16];
                port_pkg::ADDR_POWER: state_next.rdata = state_reg.power_control;
                port_pkg::ADDR_INDEX: state_next.rdata = {6'h00, state_reg.port_select_index};
                port_pkg::ADDR_MODE10: state_next.rdata = state_reg.mode[pw][0];
                port_pkg::ADDR_MODE32: state_next.rdata = state_reg.mode[pw][1];
                port_pkg::ADDR_MODE54: state_next.rdata = state_reg.mode[pw][2];
                port_pkg::ADDR_MODE76: state_next.rdata = state_reg.mode[pw][3];
                port_pkg::ADDR_PINCFG: state_next.rdata = state_reg.pin_cfg;
                port_pkg::ADDR_IRQEN: state_next.rdata = state_reg.irq_en;
                default: state_next.rdata = port_pkg::RST_ZERO;
            endcase
        end
        // halt wake resumes next instruction first
        if (state_reg.power_control[port_pkg::BIT_HALT] && state_reg.wake_req) begin
            state_next.power_control[port_pkg::BIT_HALT] = 1'b0;
            state_next.resume_next = 1'b1;
        end
        // service entry a cycle later, so the synced pin level is seen
        if (state_reg.resume_next) begin
            state_next.isr_enter = state_reg.irq_en[port_pkg::BIT_GIE] &
                ((state_reg.irq_en[port_pkg::BIT_EX0] & ~state_reg.ext_s2[0]) |
                 (state_reg.irq_en[port_pkg::BIT_EX1] & ~state_reg.ext_s2[1]));
        end
        // idle ends only with global and individual enable
        if (state_reg.power_control[port_pkg::BIT_IDLE] && i_irq_pending &&
            state_reg.irq_en[port_pkg::BIT_GIE]) begin
            state_next.power_control[port_pkg::BIT_IDLE] = 1'b0;
            state_next.isr_enter = 1'b1;
        end
        if (i_isr_done) begin
            state_next.isr_enter = 1'b0;
        end
        // Wake request held only while halted, so stray pin lows are ignored
        state_next.wake_req = state_reg.power_control[port_pkg::BIT_HALT] & wake_async;
        // Registered pad controls; outputs lag latch writes by one cycle
        state_next.drv_low = c_low;
        state_next.drv_high = c_high;
        state_next.pull_up = c_pu;
        state_next.pull_down = c_pd;
        state_next.in_en = c_in;
        state_next.analog = c_an;
        state_next.pwm = c_pw;
        state_next.lcd = c_lc;
        state_next.wake_cap = c_wk;
        state_next.high_sink = {20'h00000, {4{state_reg.pin_cfg[port_pkg::BIT_HS2]}}} << 16 |
            {8'h00, {8{state_reg.pin_cfg[port_pkg::BIT_HS1]}}, 2'h0,
             {6{state_reg.pin_cfg[port_pkg::BIT_HS0]}}};
    end

    // All state in one register; reset loads constants only
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= '0;
            state_reg.port0_data_latch <= port_pkg::RST_PORT0;
            state_reg.port1_data_latch <= port_pkg::RST_PORT13;
            state_reg.port3_data_latch <= port_pkg::RST_PORT13;
            // mode fields reset to plain open drain
            for (int p = 0; p < 3; p++) begin
                for (int r = 0; r < 4; r++) begin
                    state_reg.mode[p][r] <= port_pkg::RST_MODE;
                end
            end
            state_reg.in_en <= 24'hFFFFFF;
            state_reg.wake_cap <= 24'hFFFFFF;
            state_reg.ext_s1 <= 2'h3;
            state_reg.ext_s2 <= 2'h3;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign o_sfr_rdata = state_reg.rdata;
    assign o_drv_low = state_reg.drv_low;
    assign o_drv_high = state_reg.drv_high;
    assign o_pull_up = state_reg.pull_up;
    assign o_pull_down = state_reg.pull_down;
    assign o_in_en = state_reg.in_en;
    assign o_analog = state_reg.analog;
    assign o_pwm = state_reg.pwm;
    assign o_lcd = state_reg.lcd;
    assign o_wake_cap = state_reg.wake_cap;
    assign o_high_sink = state_reg.high_sink;
    assign o_halt = state_reg.power_control[port_pkg::BIT_HALT];
    assign o_idle = state_reg.power_control[port_pkg::BIT_IDLE];
    assign o_wake_req = state_reg.wake_req;
    assign o_isr_enter = state_reg.isr_enter;
    assign o_resume_next = state_reg.resume_next;
endmodule : port_pin_mode_wakeup

// file: dv/port_pin_mode_wakeup_props.sv
// Checker of pad control, high sink and power mode outputs
`timescale 1ns/10ps
module port_pin_mode_wakeup_props (
    input wire logic i_clk, // System clock
    input wire logic i_rst_b, // Reset, active low
    input wire logic [7:0] i_sfr_addr, // Register address
    input wire logic i_sfr_wr, // Write strobe
    input wire logic [7:0] i_sfr_wdata, // Write data
    input wire logic i_irq_pending, // Enabled interrupt pending
    input wire logic [23:0] o_drv_low, // Pad drive low
    input wire logic [23:0] o_drv_high, // Pad drive high
    input wire logic [23:0] o_pull_up, // Pull-up on
    input wire logic [23:0] o_pull_down, // Pull-down on
    input wire logic [23:0] o_in_en, // Digital input on
    input wire logic [23:0] o_analog, // Analog routing
    input wire logic [23:0] o_pwm, // PWM routing
    input wire logic [23:0] o_lcd, // LCD routing
    input wire logic [23:0] o_wake_cap, // Wake capable
    input wire logic [23:0] o_high_sink, // High sink
    input wire logic o_halt, // Halt active
    input wire logic o_idle, // Idle active
    input wire logic o_wake_req, // Halt wake request
    input wire logic o_resume_next // Post halt pulse
);
    // One clock domain, all checks quiet while reset is low
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    // Power register write decode, used by the halt entry check
    wire pwr_wr = i_sfr_wr && (i_sfr_addr == port_pkg::ADDR_POWER);
    low_off_a: assert property ((o_drv_low & (o_pull_up | o_pull_down | o_in_en)) == 24'h0)
        else $error("pin driven low with a pull or input on");
    push_pull_a: assert property ((o_drv_high & (o_drv_low | o_pull_up | o_in_en)) == 24'h0)
        else $error("push-pull pin with pull or input on");
    alt_off_a: assert property (((o_analog | o_pwm | o_lcd) & (o_in_en | o_drv_low)) == 24'h0)
        else $error("routed pin with input or drive on");
    wake_od_a: assert property ((o_wake_cap & (o_drv_high | o_analog | o_pwm | o_lcd)) == 24'h0)
        else $error("wake capable pin not in open drain mode");
    sink_groups_a: assert property ((o_high_sink & 24'hF000C0) == 24'h0)
        else $error("high sink on a pin outside its group");
    halt_enter_a: assert property (pwr_wr && i_sfr_wdata[1] |=> o_halt)
        else $error("halt not entered after power write");
    idle_hold_a: assert property (o_idle && !i_irq_pending && !i_sfr_wr |=> o_idle)
        else $error("idle left without a pending interrupt");
    idle_exit_a: assert property ($fell(o_idle) |-> $past(i_irq_pending))
        else $error("idle ended with nothing pending");
    halt_wake_a: assert property (o_halt && o_wake_req |=> !o_halt && o_resume_next)
        else $error("wake request did not end halt");
    resume_pulse_a: assert property (o_resume_next |=> !o_resume_next)
        else $error("resume pulse longer than one cycle");
    // Main scenarios reached
    cover property ($fell(o_halt));
    cover property ($fell(o_idle));
    cover property (o_high_sink != 24'h0);
endmodule : port_pin_mode_wakeup_props

// file: dv/board_model.sv
// Board signals on the pads of ports 0, 1 and 3
`timescale 1ns/10ps
module board_model (
    input wire logic i_clk, // System clock
    input wire logic [23:0] i_drv_low, // Pad driven low
    input wire logic [23:0] i_drv_high, // Pad driven high
    input wire logic [23:0] i_pull_up, // Pull-up on
    input wire logic [23:0] i_pull_down, // Pull-down on
    input wire logic [23:0] i_ext_en, // Board drives the pad
    input wire logic [23:0] i_ext_level, // Board level
    output logic [23:0] o_pin // Resulting pad level
);
    logic float_bit = 1'h0;
    // An undriven pad changes every cycle, so a stale value never reads back
    always_ff @(posedge i_clk) begin
        float_bit <= ~float_bit;
    end
    // Released driver lets the board level or pull through
    always_comb begin
        for (int b = 0; b < 24; b++) begin
            o_pin[b] = i_drv_low[b] ? 1'h0 : i_drv_high[b] ? 1'h1 : i_ext_en[b] ? i_ext_level[b] :
                (i_pull_up[b] != i_pull_down[b]) ? i_pull_up[b] : float_bit;
        end
    end
endmodule : board_model

// file: dv/port_pin_mode_wakeup_bench.sv
// Self-checking bench for the pin mode, port latch and power mode block
`timescale 1ns/10ps
`define CHK(n, e, g) \
    begin \
        checks++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("wrong value %s expected %0h seen %0h", n, e, g); \
        end \
    end
module port_pin_mode_wakeup_bench;
    typedef struct packed {logic [3:0] mode; logic lat; logic [8:0] exp;} row_t;
    typedef struct packed {logic [7:0] a; logic [7:0] v;} reg_row_t;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'h0;
    logic sfr_rd = 1'h0;
    logic sfr_rmw = 1'h0;
    logic [1:0] ext_irq = 2'h3;
    logic irq_pending = 1'h0;
    logic isr_done = 1'h0;
    logic [23:0] ext_en = 24'hFFFFFF;
    logic [23:0] ext_level = 24'hFFFFFF;
    logic [23:0] pin, drv_low, drv_high, pull_up, pull_down, in_en, analog, pwm, lcd, wake_cap;
    logic [23:0] high_sink;
    logic [7:0] rdata, rd_val;
    logic halt, idle, isr_enter, resume_next;
    int num_errors = 0;
    int checks = 0;
    // Pad outputs of one pin as {low, high, up, down, in, analog, pwm, lcd, wake}
    row_t rows [20] = '{'{4'h0,1'h1,9'h051}, '{4'h0,1'h0,9'h101}, '{4'h1,1'h1,9'h011},
        '{4'h1,1'h0,9'h101}, '{4'h2,1'h1,9'h080}, '{4'h2,1'h0,9'h100}, '{4'h3,1'h1,9'h008},
        '{4'h4,1'h1,9'h031}, '{4'h4,1'h0,9'h101}, '{4'h5,1'h1,9'h011}, '{4'h6,1'h1,9'h080},
        '{4'h7,1'h1,9'h000}, '{4'h8,1'h1,9'h051}, '{4'h9,1'h1,9'h011}, '{4'hA,1'h1,9'h080},
        '{4'hB,1'h0,9'h004}, '{4'hC,1'h1,9'h031}, '{4'hD,1'h1,9'h011}, '{4'hE,1'h1,9'h080},
        '{4'hF,1'h1,9'h062}};
    reg_row_t regs [12] = '{'{port_pkg::ADDR_PORT0, 8'h3F}, '{port_pkg::ADDR_PORT1, 8'hFF},
        '{port_pkg::ADDR_PORT3, 8'hFF}, '{port_pkg::ADDR_INDEX, 8'h00}, '{port_pkg::ADDR_POWER, 8'h00},
        '{port_pkg::ADDR_MODE10, 8'h11}, '{port_pkg::ADDR_MODE32, 8'h11}, '{port_pkg::ADDR_MODE54, 8'h11},
        '{port_pkg::ADDR_MODE76, 8'h11}, '{port_pkg::ADDR_IRQEN, 8'h00}, '{8'hC0, 8'h00},
        '{port_pkg::ADDR_PINCFG, 8'h00}};
    logic [23:0] sink_exp [3] = '{24'h00003F, 24'h00FF00, 24'h0F0000};

    port_pin_mode_wakeup uut (.i_clk(clk), .i_rst_b(rst_b), .i_sfr_addr(sfr_addr),
        .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .i_sfr_rmw(sfr_rmw), .i_sfr_wdata(sfr_wdata),
        .i_pin0(pin[7:0]), .i_pin1(pin[15:8]), .i_pin3(pin[23:16]), .i_ext_irq_pin(ext_irq),
        .i_irq_pending(irq_pending), .i_isr_done(isr_done), .o_sfr_rdata(rdata),
        .o_drv_low(drv_low), .o_drv_high(drv_high), .o_pull_up(pull_up), .o_pull_down(pull_down),
        .o_in_en(in_en), .o_analog(analog), .o_pwm(pwm), .o_lcd(lcd), .o_wake_cap(wake_cap),
        .o_high_sink(high_sink), .o_halt(halt), .o_idle(idle), .o_wake_req(),
        .o_isr_enter(isr_enter), .o_resume_next(resume_next));
    board_model board (.i_clk(clk), .i_drv_low(drv_low), .i_drv_high(drv_high),
        .i_pull_up(pull_up), .i_pull_down(pull_down), .i_ext_en(ext_en),
        .i_ext_level(ext_level), .o_pin(pin));

    // 20 MHz system clock
    always #25 clk = ~clk;

    function automatic logic [8:0] pad(input int b);
        return {drv_low[b], drv_high[b], pull_up[b], pull_down[b], in_en[b], analog[b], pwm[b],
            lcd[b], wake_cap[b]};
    endfunction : pad
    // Bus cycles change at the falling edge and hold across the taking edge
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'h1;
        @(negedge clk);
        sfr_wr = 1'h0;
    endtask : sfr_write
    task automatic sfr_read(input logic [7:0] a, input logic rmw);
        @(negedge clk);
        sfr_addr = a;
        sfr_rmw = rmw;
        sfr_rd = 1'h1;
        @(negedge clk);
        sfr_rd = 1'h0;
        sfr_rmw = 1'h0;
        @(negedge clk);
        rd_val = rdata;
    endtask : sfr_read
    task automatic do_reset;
        @(negedge clk);
        rst_b = 1'h0;
        repeat (6) @(negedge clk);
        rst_b = 1'h1;
    endtask : do_reset
    // Bounded wait for the post halt pulse, then release the wake pins
    task automatic wake_check(input logic exp_isr);
        for (int n = 0; n < 20 && resume_next !== 1'h1; n++) begin
            @(posedge clk);
            #1;
        end
        `CHK("resume", 1'h1, resume_next);
        `CHK("halt", 1'h0, halt);
        @(posedge clk);
        #1;
        `CHK("isr", exp_isr, isr_enter);
        @(negedge clk);
        ext_irq = 2'h3;
        ext_level = 24'hFFFFFF;
        isr_done = 1'h1;
        @(negedge clk);
        isr_done = 1'h0;
    endtask : wake_check
    task automatic complete_run;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // Cut a hang short; the sequence needs well under a thousand cycles
    initial begin
        #(50 * 5000);
        num_errors++;
        complete_run();
    end

    initial begin
        do_reset();
        foreach (regs[i]) begin
            sfr_read(regs[i].a, 1'h1);
            `CHK("reset value", regs[i].v, rd_val);
        end
        `CHK("in_en", 24'hFFFF3F, in_en);
        // Every mode on port 1 pin 1, pin 0 stays plain open drain
        sfr_write(port_pkg::ADDR_INDEX, 8'h01);
        foreach (rows[i]) begin
            sfr_write(port_pkg::ADDR_PORT1, {6'h3F, rows[i].lat, 1'h1});
            sfr_write(port_pkg::ADDR_MODE10, {rows[i].mode, 4'h1});
            repeat (3) @(negedge clk);
            `CHK("pad p1.1", rows[i].exp, pad(9));
            `CHK("pad p1.0", 9'h011, pad(8));
        end
        // Latch against pad level
        ext_level = 24'h000000;
        sfr_write(port_pkg::ADDR_PORT1, 8'h5A);
        sfr_read(port_pkg::ADDR_PORT1, 1'h1);
        `CHK("latch", 8'h5A, rd_val);
        sfr_read(port_pkg::ADDR_PORT1, 1'h0);
        `CHK("pads", 8'h00, rd_val);
        ext_level = 24'hFFFFFF;
        sfr_write(port_pkg::ADDR_PORT1, 8'hFF);
        // Index two refused; the index steers the pair registers
        sfr_write(port_pkg::ADDR_INDEX, 8'h03);
        sfr_write(port_pkg::ADDR_INDEX, 8'h02);
        sfr_read(port_pkg::ADDR_INDEX, 1'h0);
        `CHK("index", 8'h03, rd_val);
        sfr_write(port_pkg::ADDR_MODE76, 8'h21);
        repeat (3) @(negedge clk);
        `CHK("pad p3.7", 9'h080, pad(23));
        `CHK("pad p3.6", 9'h011, pad(22));
        sfr_write(port_pkg::ADDR_INDEX, 8'h00);
        sfr_read(port_pkg::ADDR_MODE76, 1'h0);
        `CHK("mode76", 8'h11, rd_val);
        // One high sink group at a time
        for (int g = 0; g < 3; g++) begin
            sfr_write(port_pkg::ADDR_PINCFG, 8'(8'h20 << g));
            repeat (2) @(negedge clk);
            `CHK("sink", sink_exp[g], high_sink);
        end
        sfr_write(port_pkg::ADDR_PINCFG, 8'h00);
        // External pin wake with and without global enable
        for (int k = 0; k < 2; k++) begin
            sfr_write(port_pkg::ADDR_IRQEN, k[0] ? 8'h81 : 8'h01);
            sfr_write(port_pkg::ADDR_POWER, 8'h02);
            `CHK("halt", 1'h1, halt);
            ext_irq = 2'h2;
            wake_check(k[0]);
        end
        // Open drain pad low wakes halt with no enable set
        sfr_write(port_pkg::ADDR_IRQEN, 8'h00);
        sfr_write(port_pkg::ADDR_POWER, 8'h02);
        ext_level[8] = 1'h0;
        wake_check(1'h0);
        // Idle ignores a pending interrupt until global enable is set
        sfr_write(port_pkg::ADDR_IRQEN, 8'h01);
        sfr_write(port_pkg::ADDR_POWER, 8'h01);
        irq_pending = 1'h1;
        repeat (4) @(negedge clk);
        `CHK("idle", 1'h1, idle);
        sfr_write(port_pkg::ADDR_IRQEN, 8'h81);
        repeat (2) @(negedge clk);
        `CHK("idle", 1'h0, idle);
        `CHK("isr", 1'h1, isr_enter);
        irq_pending = 1'h0;
        // Second reset in mid-run
        do_reset();
        sfr_read(port_pkg::ADDR_IRQEN, 1'h0);
        `CHK("irqen", 8'h00, rd_val);
        complete_run();
    end
endmodule : port_pin_mode_wakeup_bench

bind port_pin_mode_wakeup port_pin_mode_wakeup_props chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
    .i_irq_pending(i_irq_pending), .o_drv_low(o_drv_low), .o_drv_high(o_drv_high),
    .o_pull_up(o_pull_up), .o_pull_down(o_pull_down), .o_in_en(o_in_en), .o_analog(o_analog),
    .o_pwm(o_pwm), .o_lcd(o_lcd), .o_wake_cap(o_wake_cap), .o_high_sink(o_high_sink),
    .o_halt(o_halt), .o_idle(o_idle), .o_wake_req(o_wake_req), .o_resume_next(o_resume_next));
